// ==== rtl/cbce_bus_encode.sv ====
// Bus cycle encoder with pin float control and scan sampling
// Summary of operation
// RULE1 - Sampled backoff floats upper address, address parity, data, parity. In scan mode only data and parity float, once the cycle drops to idle.
// RULE2 - Asserting hold acknowledge floats upper address, parity, data lines.
// RULE3 - Address hold floats only upper address and parity, not data. In scan mode the code never floats the address on address hold.
// RULE4 - Tri-state test floats all outputs but supply detect and scan out.
// RULE5 - Scan data and mode inputs sampled on rising test clock.
// RULE6 - Scan data output changes on falling test clock.
// RULE7 - In scan mode inputs sample on test rise, outputs on test fall.
// RULE8 - Code read fills a line only when intent and acknowledge both low.
// RULE9 - Data read fills a line only when intent and acknowledge both low.
// RULE10 - Memory write encodes 1,1,1; intent low for writeback, else high.
// RULE11 - I/O cycles encode 0,1, intent high, write/read per direction.
// RULE12 - Special cycle encodes 0,0,1; interrupt ack 0,0,0; intent high.
// RULE13 - Stop grant and halt pull lane 2 low, bit 4 tells them apart.
// RULE14 - Other specials: bit 4 low, one lane low names the cycle.
// RULE15 - Bus signals sampled and driven on rising bus clock edges.
// RULE16 - Frequency select captured at reset release only.
// RULE17 - Purge request captured at reset release and on clock edges.
// RULE18 - Active-low signals are asserted low, active-high asserted high.
// RULE19 - Far party trusts address only while strobe is asserted.
`timescale 1ns/1ps
`include "cbce_params.svh"

module cbce_bus_encode (
   input  wire logic                clk_i,
   input  wire logic                rst_b_i,
   input  wire logic                cyc_req_i,
   input  wire cbce_pkg::cbce_kind_t cyc_kind_i,
   input  wire cbce_pkg::cbce_spec_t cyc_spec_i,
   input  wire logic                want_fill_i,
   input  wire logic [31:3]         addr_i,
   input  wire logic [7:0]          lanes_n_i,
   input  wire logic [63:0]         wr_data_i,
   input  wire logic                last_ready_i,
   input  wire logic                cacheable_ack_n_i,
   input  wire logic                backoff_n_i,
   input  wire logic                addr_hold_i,
   input  wire logic                hold_req_i,
   input  wire logic                tristate_test_i,
   input  wire logic [2:0]          bus_freq_select_i,
   input  wire logic                purge_req_n_i,
   input  wire logic                scan_mode_i,
   input  wire logic                tck_i,
   input  wire logic                tdi_i,
   input  wire logic                tms_i,
   input  wire logic                trst_n_i,
   output logic                     addr_strobe_n_o,
   output logic                     mem_io_o,
   output logic                     data_code_o,
   output logic                     write_read_o,
   output logic                     line_fill_n_o,
   output logic                     addr_bit4_o,
   output logic [7:0]               lane_enable_n_o,
   output logic                     ctl_oe_o,
   output logic [31:5]              addr_hi_o,
   output logic                     address_parity_o,
   output logic                     addr_oe_o,
   output logic [63:0]              data_o,
   output logic [7:0]               data_parity_o,
   output logic                     data_oe_o,
   output logic                     hold_ack_o,
   output logic                     hold_ack_oe_o,
   output logic                     fill_o,
   output logic [2:0]               freq_o,
   output logic                     purge_seen_o,
   output logic                     core_supply_detect_o,
   output logic                     tdo_o
);
   import cbce_pkg::*;

   cbce_state_t                 state_reg;
   logic                        tck_reg;
   logic                        rel_reg;
   logic [`CBCE_SCAN_W-1:0]     scan_reg;
   logic                        samp_en;
   logic                        out_en;
   logic                        tck_rise;
   logic                        tck_fall;
   logic                        hold_next;
   logic                        backoff_n;

   // Encodes {mem/io, data/code, write/read, intent} for a cycle kind
   function automatic logic [3:0] enc(input cbce_kind_t k,
                                      input logic fill);
      case (k)
         CBCE_CODE_RD: enc = {3'b100, ~fill};
         CBCE_DATA_RD: enc = {3'b110, ~fill};
         CBCE_WR_BACK: enc = 4'hE;
         CBCE_WR_NC:   enc = 4'hF;
         CBCE_IO_RD:   enc = 4'h5;
         CBCE_IO_WR:   enc = 4'h7;
         CBCE_SPECIAL: enc = 4'h3;
         CBCE_INTA:    enc = 4'h1;
         default:      enc = 4'hF;
      endcase
   endfunction : enc

   // Address bit 4 and lane enables that name a special cycle
   function automatic logic [8:0] spec(input cbce_spec_t s);
      case (s)
         CBCE_SP_STOP:  spec = {1'b1, `CBCE_LANES_B2};
         CBCE_SP_HALT:  spec = {1'b0, `CBCE_LANES_B2};
         CBCE_SP_FLUSH: spec = {1'b0, `CBCE_LANES_B4};
         CBCE_SP_WBACK: spec = {1'b0, `CBCE_LANES_B3};
         CBCE_SP_INVAL: spec = {1'b0, `CBCE_LANES_B1};
         CBCE_SP_SHUT:  spec = {1'b0, `CBCE_LANES_B0};
         default:       spec = {1'b0, `CBCE_LANES_IDLE};
      endcase
   endfunction : spec

   // Test clock is a plain synchronous pin, so edges come from one register
   assign tck_rise = tck_i & ~tck_reg;
   assign tck_fall = ~tck_i & tck_reg;
   // Scan mode moves bus cycle pin timing onto the test clock edges; straps and tri-state float keep the bus clock
   assign samp_en = scan_mode_i ? tck_rise : 1'b1; // [RULE7] [RULE15]
   assign out_en  = scan_mode_i ? tck_fall : 1'b1; // [RULE7]
   assign backoff_n    = samp_en & ~backoff_n_i;        // [RULE18]
   assign hold_next = hold_req_i & (state_reg == CBCE_IDLE) & ~backoff_n;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tck_reg <= 1'b0;
      end else begin
         tck_reg <= tck_i;
      end
   end

   // Bus cycle sequence; backoff drops any cycle back to idle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= CBCE_IDLE;
      end else if (samp_en) begin
         if (backoff_n) begin
            state_reg <= CBCE_IDLE; // [RULE1]
         end else begin
            case (state_reg)
               CBCE_IDLE: begin
                  if (cyc_req_i && !hold_req_i) begin
                     state_reg <= CBCE_ADDR;
                  end
               end
               CBCE_ADDR: state_reg <= CBCE_DATA;
               CBCE_DATA: begin
                  if (last_ready_i) begin
                     state_reg <= CBCE_IDLE;
                  end
               end
               default: state_reg <= CBCE_IDLE;
            endcase
         end
      end
   end

   // Cycle type, lanes and address launch with the strobe and then hold
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_strobe_n_o <= 1'b1;
         mem_io_o        <= 1'b0;
         data_code_o     <= 1'b0;
         write_read_o    <= 1'b0;
         line_fill_n_o   <= 1'b1;
         addr_bit4_o     <= 1'b0;
         lane_enable_n_o <= `CBCE_LANES_IDLE;
         addr_hi_o       <= 27'h0;
         address_parity_o <= 1'b0;
         data_o          <= 64'h0;
         data_parity_o   <= 8'h0;
      end else if (out_en) begin
         addr_strobe_n_o <= 1'b1;
         if (state_reg == CBCE_IDLE && cyc_req_i && !hold_req_i
             && !backoff_n) begin
            addr_strobe_n_o <= 1'b0;
            {mem_io_o, data_code_o, write_read_o, line_fill_n_o}
               <= enc(cyc_kind_i, want_fill_i); // [RULE10] [RULE11] [RULE12]
            if (cyc_kind_i == CBCE_SPECIAL) begin
               {addr_bit4_o, lane_enable_n_o}
                  <= spec(cyc_spec_i); // [RULE13] [RULE14]
            end else begin
               addr_bit4_o     <= addr_i[4];
               lane_enable_n_o <= lanes_n_i;
            end
            addr_hi_o        <= addr_i[31:5];
            address_parity_o <= ^addr_i[31:3];
            data_o           <= wr_data_i;
            for (int i = 0; i < 8; i++) begin
               data_parity_o[i] <= ^wr_data_i[8*i +: 8];
            end
         end
      end
   end

   // Read outcome: a fill needs both sides to agree on cacheability
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fill_o <= 1'b0;
      end else if (samp_en) begin
         if (state_reg == CBCE_DATA && last_ready_i && !write_read_o
             && mem_io_o && !backoff_n) begin
            fill_o <= ~line_fill_n_o & ~cacheable_ack_n_i; // [RULE8] [RULE9]
         end
      end
   end

   // Hold acknowledge is granted only between cycles
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hold_ack_o <= 1'b0;
      end else if (out_en) begin
         hold_ack_o <= hold_next;
      end
   end

   // Float control is computed from next-edge causes so it lands on that edge
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctl_oe_o      <= 1'b0;
         addr_oe_o     <= 1'b0;
         data_oe_o     <= 1'b0;
         hold_ack_oe_o <= 1'b0;
      end else begin
         hold_ack_oe_o <= ~tristate_test_i; // [RULE4]
         if (tristate_test_i) begin
            ctl_oe_o  <= 1'b0; // [RULE4]
            addr_oe_o <= 1'b0;
            data_oe_o <= 1'b0;
         end else if (out_en) begin
            ctl_oe_o  <= ~hold_next & ~backoff_n; // [RULE1] [RULE2]
            addr_oe_o <= ~hold_next & ~backoff_n
                         & ~(samp_en & addr_hold_i); // [RULE3]
            // Data pins follow the write data phase only, not address hold
            data_oe_o <= ~hold_next & ~backoff_n & write_read_o
                         & (state_reg == CBCE_DATA); // [RULE1] [RULE2]
         end
      end
   end

   // Straps: frequency only at release, purge at release and every edge
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rel_reg      <= 1'b0;
         freq_o       <= 3'h0;
         purge_seen_o <= 1'b0;
      end else begin
         rel_reg <= 1'b1;
         if (!rel_reg) begin
            freq_o <= bus_freq_select_i; // [RULE16]
         end
         if (!purge_req_n_i) begin
            purge_seen_o <= 1'b1; // [RULE17]
         end
      end
   end

   // Supply detect is a fixed low level that never floats
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         core_supply_detect_o <= 1'b0;
      end else begin
         core_supply_detect_o <= 1'b0;
      end
   end

   // Scan register: mode high captures pins, low shifts serial data in
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scan_reg <= '0;
      end else if (!trst_n_i) begin
         scan_reg <= '0;
      end else if (tck_rise) begin
         if (tms_i) begin // [RULE5]
            scan_reg <= {backoff_n_i, addr_hold_i, hold_req_i,
                         cacheable_ack_n_i, last_ready_i, cyc_req_i,
                         purge_req_n_i, tdi_i};
         end else begin
            scan_reg <= {tdi_i, scan_reg[`CBCE_SCAN_W-1:1]}; // [RULE5]
         end
      end
   end

   // Serial out moves on the falling test edge, half a period after shift
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tdo_o <= 1'b0;
      end else if (!trst_n_i) begin
         tdo_o <= 1'b0;
      end else if (tck_fall) begin
         tdo_o <= scan_reg[0]; // [RULE6]
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   backoff_float_a: assert property ( // [RULE1]
      !backoff_n_i && !scan_mode_i |=> !addr_oe_o && !data_oe_o)
      else $error("pins driven after backoff");
   hold_float_a: assert property ( // [RULE2]
      hold_ack_o |-> !addr_oe_o && !data_oe_o && !ctl_oe_o)
      else $error("pins driven during hold acknowledge");
   addr_hold_a: assert property ( // [RULE3]
      addr_hold_i && !scan_mode_i |=> !addr_oe_o)
      else $error("address driven under address hold");
   tristate_float_a: assert property ( // [RULE4]
      tristate_test_i |=> !ctl_oe_o && !addr_oe_o && !data_oe_o
                          && !hold_ack_oe_o)
      else $error("output driven in tri-state test");
   tdo_edge_a: assert property ( // [RULE6]
      !$stable(tdo_o) |-> $past(tck_fall))
      else $error("scan out changed off falling test edge");
   scan_drive_a: assert property ( // [RULE7]
      !$stable(addr_strobe_n_o) |-> $past(out_en))
      else $error("strobe moved off its drive edge");
   fill_decide_a: assert property ( // [RULE8]
      samp_en && state_reg == CBCE_DATA && last_ready_i && mem_io_o
      && !write_read_o && !backoff_n |=> fill_o == $past(~line_fill_n_o
      & ~cacheable_ack_n_i))
      else $error("line fill decision wrong");
   special_lane_a: assert property ( // [RULE14]
      !addr_strobe_n_o && !mem_io_o && !data_code_o && write_read_o
      |-> $countones(~lane_enable_n_o) == 1)
      else $error("special cycle lane code wrong");
   freq_strap_a: assert property ( // [RULE16]
      $rose(rel_reg) |-> freq_o == $past(bus_freq_select_i) ##1
      freq_o == $past(freq_o))
      else $error("frequency strap not held");
endmodule : cbce_bus_encode

// ==== rtl/cbce_params.svh ====
// Constants for the bus cycle encoder: lane codes and scan register width
`ifndef CBCE_PARAMS_SVH
`define CBCE_PARAMS_SVH
`define CBCE_LANES_IDLE 8'hFF
`define CBCE_LANES_B2   8'hFB
`define CBCE_LANES_B4   8'hEF
`define CBCE_LANES_B3   8'hF7
`define CBCE_LANES_B1   8'hFD
`define CBCE_LANES_B0   8'hFE
`define CBCE_SCAN_W     8
`endif

// ==== rtl/cbce_pkg.sv ====
// Types shared by the bus cycle encoder
package cbce_pkg;
   typedef enum logic [2:0] {
      CBCE_CODE_RD = 3'h0, CBCE_DATA_RD = 3'h1, CBCE_WR_BACK = 3'h2,
      CBCE_WR_NC   = 3'h3, CBCE_IO_RD   = 3'h4, CBCE_IO_WR   = 3'h5,
      CBCE_SPECIAL = 3'h6, CBCE_INTA    = 3'h7
   } cbce_kind_t;
   typedef enum logic [2:0] {
      CBCE_SP_STOP  = 3'h0, CBCE_SP_FLUSH = 3'h1, CBCE_SP_WBACK = 3'h2,
      CBCE_SP_HALT  = 3'h3, CBCE_SP_INVAL = 3'h4, CBCE_SP_SHUT  = 3'h5
   } cbce_spec_t;
   typedef enum logic [1:0] {
      CBCE_IDLE = 2'b00, CBCE_ADDR = 2'b01, CBCE_DATA = 2'b10
   } cbce_state_t;
endpackage : cbce_pkg

// ==== verif/cbce_bus_cycle_encode_float_tb.sv ====
// Self-checking bench for the bus cycle encoder
`timescale 1ns/1ps
`include "cbce_params.svh"
module cbce_bus_cycle_encode_float_tb;
   import cbce_pkg::*;
   logic clk_i, rst_b_i, cyc_req_i, want_fill_i, last_ready_i, ack_n;
   logic backoff_n_i, addr_hold_i, hold_req_i, tristate_test_i, ken_n;
   logic purge_req_n_i, tck_i, tdi_i, strb_n, mio, dc, wr, lfn, a4;
   logic ctl_oe, addr_oe, address_parity_o, data_oe, hack, hack_oe, fill_o;
   logic purge_seen_o, core_supply_detect_o, tdo_o;
   logic scan_mode, tms;
   cbce_kind_t  cyc_kind_i;
   cbce_spec_t  cyc_spec_i;
   logic [31:3] addr_i;
   logic [31:5] addr_hi_o;
   logic [7:0]  lanes_n_i, lanes_o, data_parity_o;
   logic [63:0] wr_data_i, data_o;
   logic [2:0]  bus_freq_select_i, freq_o, fs;
   logic [3:0]  wt;
   logic [31:0] seed = 32'hAB2A;
   int          fails = 0;
   int          n_compared = 0;

   cbce_bus_encode uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .cyc_req_i(cyc_req_i), .cyc_kind_i(cyc_kind_i), .cyc_spec_i(cyc_spec_i),
      .want_fill_i(want_fill_i), .addr_i(addr_i), .lanes_n_i(lanes_n_i),
      .wr_data_i(wr_data_i), .last_ready_i(last_ready_i),
      .cacheable_ack_n_i(ack_n), .backoff_n_i(backoff_n_i),
      .addr_hold_i(addr_hold_i), .hold_req_i(hold_req_i),
      .tristate_test_i(tristate_test_i), .bus_freq_select_i(bus_freq_select_i),
      .purge_req_n_i(purge_req_n_i), .scan_mode_i(scan_mode), .tck_i(tck_i),
      .tdi_i(tdi_i), .tms_i(tms), .trst_n_i(1'b1), .addr_strobe_n_o(strb_n),
      .mem_io_o(mio), .data_code_o(dc), .write_read_o(wr),
      .line_fill_n_o(lfn), .addr_bit4_o(a4), .lane_enable_n_o(lanes_o),
      .ctl_oe_o(ctl_oe), .addr_hi_o(addr_hi_o),
      .address_parity_o(address_parity_o), .addr_oe_o(addr_oe),
      .data_o(data_o), .data_parity_o(data_parity_o), .data_oe_o(data_oe),
      .hold_ack_o(hack), .hold_ack_oe_o(hack_oe), .fill_o(fill_o),
      .freq_o(freq_o), .purge_seen_o(purge_seen_o),
      .core_supply_detect_o(core_supply_detect_o), .tdo_o(tdo_o));
   cbce_chipset chip (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .addr_strobe_n_i(strb_n), .wait_i(wt), .ken_n_i(ken_n),
      .last_ready_o(last_ready_i), .cacheable_ack_n_o(ack_n));

   // Free-running bus clock, 4 ns period
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Pin code {mem/io, data/code, write/read, intent_n, bit4, lanes}
   function automatic logic [12:0] exp_enc(cbce_kind_t k, cbce_spec_t s,
                                           logic wf, logic b4, logic [7:0] ln);
      case (k)
         CBCE_CODE_RD: return {3'b100, ~wf, b4, ln};
         CBCE_DATA_RD: return {3'b110, ~wf, b4, ln};
         CBCE_WR_BACK: return {4'b1110, b4, ln};
         CBCE_WR_NC:   return {4'b1111, b4, ln};
         CBCE_IO_RD:   return {4'b0101, b4, ln};
         CBCE_IO_WR:   return {4'b0111, b4, ln};
         CBCE_INTA:    return {4'b0001, b4, ln};
         default: case (s)
            CBCE_SP_STOP:  return {5'b00111, `CBCE_LANES_B2};
            CBCE_SP_FLUSH: return {5'b00110, `CBCE_LANES_B4};
            CBCE_SP_WBACK: return {5'b00110, `CBCE_LANES_B3};
            CBCE_SP_HALT:  return {5'b00110, `CBCE_LANES_B2};
            CBCE_SP_INVAL: return {5'b00110, `CBCE_LANES_B1};
            default:       return {5'b00110, `CBCE_LANES_B0};
         endcase
      endcase
   endfunction : exp_enc

   task automatic chk(input string nm, input logic [63:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask : tick

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   // Reset with a random strap; purge may be held low across the release
   task automatic do_reset(input logic pg);
      rst_b_i = 1'b0;
      purge_req_n_i = ~pg;
      fs = 3'(rnd());
      bus_freq_select_i = fs;
      repeat (3) tick();
      rst_b_i = 1'b1;
      tick();
      chk("freq", freq_o, fs);
      chk("purge", purge_seen_o, pg);
      purge_req_n_i = 1'b1;
      bus_freq_select_i = ~fs;
      tick();
      chk("freq kept", freq_o, fs);
   endtask : do_reset

   // One whole bus cycle; ah raises address hold, then backoff, in data phase
   task automatic run_cyc(input cbce_kind_t k, input cbce_spec_t s,
                          input logic wf, kn, ah);
      logic [12:0] e;
      logic [7:0]  dp;
      int          i;
      tick();
      cyc_kind_i = k;
      cyc_spec_i = s;
      want_fill_i = wf;
      ken_n = kn;
      addr_i = 29'(rnd());
      lanes_n_i = 8'(rnd());
      wr_data_i = {rnd(), rnd()};
      wt = ah ? 4'h4 : 4'(rnd() % 4);
      e = exp_enc(k, s, wf, addr_i[4], lanes_n_i);
      // Even parity per byte lane of the write data
      for (int b = 0; b < 8; b++) dp[b] = ^wr_data_i[8*b +: 8];
      cyc_req_i = 1'b1;
      i = 0;
      while (strb_n !== 1'b0 && i < 20) begin
         tick();
         i++;
      end
      cyc_req_i = 1'b0;
      chk("strobe wait", i < 20, 1'b1);
      chk("kind", {mio, dc, wr, lfn}, e[12:9]);
      chk("lanes", {a4, lanes_o}, e[8:0]);
      chk("addr", {addr_hi_o, address_parity_o},
          {addr_i[31:5], ^addr_i});
      chk("data", data_o, wr_data_i);
      chk("dpar", data_parity_o, dp);
      if (ah) begin
         addr_hold_i = 1'b1;
         repeat (2) tick();
         chk("addr_hold", {addr_oe, data_oe, ctl_oe}, 3'b011);
         addr_hold_i = 1'b0;
         // Backoff while write data is driven must float the data pins too
         backoff_n_i = 1'b0;
         tick();
         chk("backoff_n data", {addr_oe, data_oe, ctl_oe}, 3'b000);
         backoff_n_i = 1'b1;
      end
      i = 0;
      while (last_ready_i !== 1'b1 && i < 30) begin
         tick();
         i++;
      end
      chk("ready wait", i < 30, 1'b1);
      tick();
      if (k == CBCE_CODE_RD || k == CBCE_DATA_RD)
         chk("fill", fill_o, wf & ~kn);
   endtask : run_cyc

   initial begin : main
      logic [15:0] pat;
      logic [7:0]  cap;
      logic        t;
      {cyc_req_i, want_fill_i, addr_hold_i, hold_req_i, tristate_test_i} = '0;
      {backoff_n_i, ken_n, tck_i, tdi_i} = 4'h8;
      {scan_mode, tms} = 2'b00;
      cyc_kind_i = CBCE_CODE_RD;
      cyc_spec_i = CBCE_SP_STOP;
      {addr_i, lanes_n_i, wr_data_i, wt} = '0;
      do_reset(1'b1);
      for (int k = 0; k < 8; k++) run_cyc(cbce_kind_t'(k), CBCE_SP_STOP,
                                          1'(rnd()), 1'(rnd()), 1'b0);
      for (int s = 0; s < 6; s++) run_cyc(CBCE_SPECIAL, cbce_spec_t'(s),
                                          1'b0, 1'b0, 1'b0);
      run_cyc(CBCE_CODE_RD, CBCE_SP_STOP, 1'b1, 1'b0, 1'b0);
      run_cyc(CBCE_DATA_RD, CBCE_SP_STOP, 1'b1, 1'b1, 1'b0);
      run_cyc(CBCE_WR_NC, CBCE_SP_STOP, 1'b0, 1'b0, 1'b1);
      for (int n = 0; n < 12; n++) run_cyc(cbce_kind_t'(3'(rnd())),
         cbce_spec_t'(rnd() % 6), 1'(rnd()), 1'(rnd()), 1'b0);
      $display("test encode done");
      // Backoff floats address, data and control one edge later
      backoff_n_i = 1'b0;
      tick();
      chk("backoff_n", {addr_oe, data_oe, ctl_oe}, 3'b000);
      backoff_n_i = 1'b1;
      repeat (2) tick();
      chk("backoff_n end", {addr_oe, ctl_oe}, 2'b11);
      // Hold acknowledge and the float come on the same edge
      hold_req_i = 1'b1;
      for (int i = 0; i < 20 && hack !== 1'b1; i++) tick();
      chk("hold_ack", {hack, hack_oe, addr_oe, data_oe, ctl_oe}, 5'h18);
      hold_req_i = 1'b0;
      tristate_test_i = 1'b1;
      repeat (2) tick();
      chk("tri", {addr_oe, data_oe, ctl_oe, hack_oe}, 4'h0);
      chk("supply", core_supply_detect_o, 1'b0);
      tristate_test_i = 1'b0;
      $display("test float done");
      // Scan mode: hold answer moves only on a test fall; pin capture at 16
      scan_mode = 1'b1;
      hold_req_i = 1'b1;
      pat = 16'(rnd());
      for (int i = 0; i < 24; i++) begin
         t = tdo_o;
         tdi_i = pat[i % 16];
         tms = (i == 16);
         tck_i = 1'b1;
         repeat (2) tick();
         chk("tdo at rise", tdo_o, t);
         if (i == 0) chk("hold_ack at rise", hack, 1'b0);
         if (i == 16) cap = {backoff_n_i, addr_hold_i, hold_req_i, ack_n,
                             last_ready_i, cyc_req_i, purge_req_n_i, tdi_i};
         tck_i = 1'b0;
         repeat (2) tick();
         if (i == 0) chk("hold_ack at fall", hack, 1'b1);
         if (i >= 16) chk("tdo cap", tdo_o, cap[i-16]);
         else if (i >= 7) chk("tdo", tdo_o, pat[i-7]);
      end
      {scan_mode, tms, hold_req_i} = 3'b000;
      $display("test scan done");
      do_reset(1'b0);
      purge_req_n_i = 1'b0;
      tick();
      purge_req_n_i = 1'b1;
      tick();
      chk("purge edge", purge_seen_o, 1'b1);
      $display("test reset done");
      report_and_stop();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #100000;
      fails++;
      report_and_stop();
   end
endmodule : cbce_bus_cycle_encode_float_tb

// ==== verif/cbce_chipset.sv ====
// Chipset model: ends each bus cycle with last ready after a wait
`timescale 1ns/1ps
module cbce_chipset (
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       addr_strobe_n_i,
   input  wire logic [3:0] wait_i,
   input  wire logic       ken_n_i,
   output logic            last_ready_o,
   output logic            cacheable_ack_n_o
);
   logic [3:0] cnt_reg;
   logic       busy_reg;
   // Cycle start is known only from the strobe; ready moves on rising edges
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_reg      <= 4'h0;
         busy_reg     <= 1'b0;
         last_ready_o <= 1'b0;
      end else begin
         last_ready_o <= 1'b0;
         if (!addr_strobe_n_i) begin
            busy_reg <= 1'b1;
            cnt_reg  <= wait_i;
         end else if (busy_reg && cnt_reg == 4'h0) begin
            busy_reg     <= 1'b0;
            last_ready_o <= 1'b1;
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 4'h1;
         end
      end
   end
   // Acknowledge is only meaningful with ready; shows the inverse elsewhere
   assign cacheable_ack_n_o = last_ready_o ? ken_n_i
                                           : ~ken_n_i;
endmodule : cbce_chipset
